/* rtl/tmr_top.sv */
// Dual timer/counter with external interrupt flags, Avalon-MM register slave.
// Assumes event and interrupt pins are synchronous to CLK_SYS.
// Overview of operation
// - Each overflow flag sets on overflow and clears when the core acknowledges that vector.
// - Each run bit written by software turns its timer on or off.
// - Interrupt 1 flag sets on a detected edge of its pin and clears on acknowledge.
// - Interrupt 1 type bit picks edge or low-level triggering.
// - Interrupt 0 flag sets on a detected edge of its pin and clears on acknowledge.
// - Interrupt 0 type bit picks falling-edge or low-level triggering.
// - Each timer holds a 16-bit count readable and writable as high and low bytes.
// - Each timer has an internal/external source selector and a gating bit.
// - Mode 00 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 01 is a full 16-bit counter.
// - Timer 1 in mode 10 counts 8 bits and reloads the low byte from the high byte.
// - Timer 0 in mode 10 counts 8 bits and reloads the low byte from the high byte.
// - Timer 1 in mode 11 is stopped.
// - Timer 0 in mode 11 splits into an event/interval counter and an interval counter.
`timescale 1ns/1ps
module tmr_top
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [tmr_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EVENT0_IN,
  input wire logic EVENT1_IN,
  input wire logic EXTINT0_IN,
  input wire logic EXTINT1_IN,
  output logic TIMER0_IRQ,
  output logic TIMER1_IRQ,
  output logic EXTINT0_IRQ,
  output logic EXTINT1_IRQ
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] mode;
    logic ev0_d;
    logic ev1_d;
    logic x0_d;
    logic x1_d;
    logic [31:0] rdata;
    logic wait_n;
    logic t0_irq;
    logic t1_irq;
    logic x0_irq;
    logic x1_irq;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;

  logic access;
  logic bus_wr;
  logic [7:0] wbyte;
  logic [7:0] t0_low;
  logic [7:0] t0_high;
  logic [7:0] t1_low;
  logic [7:0] t1_high;
  logic t0_ovf_low;
  logic t0_ovf_high;
  logic t1_ovf_low;
  logic t1_ovf_high;
  logic [1:0] t0_mode;
  logic [1:0] t1_mode;
  logic t0_enable;
  logic t1_enable;
  logic t0_tick;
  logic t1_tick;
  logic t0_high_tick;
  logic ev0_rise;
  logic ev1_rise;
  logic wr_t0_low;
  logic wr_t0_high;
  logic wr_t1_low;
  logic wr_t1_high;
  logic [7:0] rbyte;
  logic x0_set;
  logic x1_set;
  logic t0_set;
  logic t1_set;
  logic [3:0] ack;

  // One wait cycle per access; a write lands only at the edge waitrequest is low
  assign access = (AVS_READ | AVS_WRITE) & ~s_r.wait_n;
  assign bus_wr = AVS_WRITE & s_r.wait_n & AVS_BYTEENABLE[0];
  assign wbyte = AVS_WRITEDATA[7:0];
  assign wr_t0_low = bus_wr && (AVS_ADDRESS == OFS_T0_LOW);
  assign wr_t0_high = bus_wr && (AVS_ADDRESS == OFS_T0_HIGH);
  assign wr_t1_low = bus_wr && (AVS_ADDRESS == OFS_T1_LOW);
  assign wr_t1_high = bus_wr && (AVS_ADDRESS == OFS_T1_HIGH);
  assign ack = (bus_wr && (AVS_ADDRESS == OFS_VECTOR_ACK)) ? wbyte[3:0] : 4'h0;

  assign t0_mode = s_r.mode[1:0];
  assign t1_mode = s_r.mode[T1_NIB+1:T1_NIB];

  // Gate qualifies run with the interrupt pin
  assign t0_enable = s_r.control[CTL_T0_RUN]
    & (~s_r.mode[MODE_GATE] | EXTINT0_IN);
  assign t1_enable = s_r.control[CTL_T1_RUN]
    & (~s_r.mode[T1_NIB+MODE_GATE] | EXTINT1_IN)
    & (t1_mode != 2'b11);

  // Event inputs count on the rising edge; one tick per core clock at most
  assign ev0_rise = EVENT0_IN & ~s_r.ev0_d;
  assign ev1_rise = EVENT1_IN & ~s_r.ev1_d;
  assign t0_tick = t0_enable & (s_r.mode[MODE_SEL] ? ev0_rise : 1'b1);
  assign t1_tick = t1_enable & (s_r.mode[T1_NIB+MODE_SEL] ? ev1_rise : 1'b1);
  // Split mode: the high half times internally, borrowing timer 1 run bit
  assign t0_high_tick = s_r.control[CTL_T1_RUN];

  tmr_unit u_t0 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .mode(t0_mode),
    .tick_low(t0_tick),
    .tick_high(t0_high_tick),
    .wr_low(wr_t0_low),
    .wr_high(wr_t0_high),
    .wdata(wbyte),
    .low_byte(t0_low),
    .high_byte(t0_high),
    .ovf_low(t0_ovf_low),
    .ovf_high(t0_ovf_high)
  );

  tmr_unit u_t1 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .mode(t1_mode),
    .tick_low(t1_tick),
    .tick_high(1'b0),
    .wr_low(wr_t1_low),
    .wr_high(wr_t1_high),
    .wdata(wbyte),
    .low_byte(t1_low),
    .high_byte(t1_high),
    .ovf_low(t1_ovf_low),
    .ovf_high(t1_ovf_high)
  );

  // In split mode timer 0 high half takes over the timer 1 overflow flag
  assign t0_set = t0_ovf_low;
  assign t1_set = t1_ovf_low | (t0_ovf_high & (t0_mode == 2'b11));
  // Type 1: edge; type 0: low level holds the request
  assign x0_set = s_r.control[CTL_X0_TYPE] ? (s_r.x0_d & ~EXTINT0_IN) : ~EXTINT0_IN;
  assign x1_set = s_r.control[CTL_X1_TYPE] ? (s_r.x1_d ^ EXTINT1_IN) : ~EXTINT1_IN;

  always_comb
  begin
    rbyte = 8'h00;
    if (AVS_ADDRESS == OFS_CONTROL)
    begin
      rbyte = s_r.control;
    end
    else if (AVS_ADDRESS == OFS_MODE)
    begin
      rbyte = s_r.mode;
    end
    else if (AVS_ADDRESS == OFS_T0_LOW)
    begin
      rbyte = t0_low;
    end
    else if (AVS_ADDRESS == OFS_T0_HIGH)
    begin
      rbyte = t0_high;
    end
    else if (AVS_ADDRESS == OFS_T1_LOW)
    begin
      rbyte = t1_low;
    end
    else if (AVS_ADDRESS == OFS_T1_HIGH)
    begin
      rbyte = t1_high;
    end
    else
    begin
      rbyte = 8'h00;
    end
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ev0_d = EVENT0_IN;
    s_nxt.ev1_d = EVENT1_IN;
    s_nxt.x0_d = EXTINT0_IN;
    s_nxt.x1_d = EXTINT1_IN;
    s_nxt.wait_n = access;
    if (access)
    begin
      s_nxt.rdata = AVS_READ ? {24'h000000, rbyte} : 32'h00000000;
    end
    if (bus_wr && (AVS_ADDRESS == OFS_CONTROL))
    begin
      s_nxt.control = wbyte;
    end
    if (bus_wr && (AVS_ADDRESS == OFS_MODE))
    begin
      s_nxt.mode = wbyte;
    end
    // Acknowledge clears; a set in the same cycle wins
    if (ack[ACK_T0])
    begin
      s_nxt.control[CTL_T0_OVF] = 1'b0;
    end
    if (ack[ACK_T1])
    begin
      s_nxt.control[CTL_T1_OVF] = 1'b0;
    end
    if (ack[ACK_X0])
    begin
      s_nxt.control[CTL_X0_FLAG] = 1'b0;
    end
    if (ack[ACK_X1])
    begin
      s_nxt.control[CTL_X1_FLAG] = 1'b0;
    end
    if (t0_set)
    begin
      s_nxt.control[CTL_T0_OVF] = 1'b1;
    end
    if (t1_set)
    begin
      s_nxt.control[CTL_T1_OVF] = 1'b1;
    end
    if (x0_set)
    begin
      s_nxt.control[CTL_X0_FLAG] = 1'b1;
    end
    if (x1_set)
    begin
      s_nxt.control[CTL_X1_FLAG] = 1'b1;
    end
    s_nxt.t0_irq = s_nxt.control[CTL_T0_OVF];
    s_nxt.t1_irq = s_nxt.control[CTL_T1_OVF];
    s_nxt.x0_irq = s_nxt.control[CTL_X0_FLAG];
    s_nxt.x1_irq = s_nxt.control[CTL_X1_FLAG];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      s_r <= '0;
      s_r.control <= CONTROL_RST;
      s_r.mode <= MODE_RST;
      s_r.ev0_d <= 1'b1;
      s_r.ev1_d <= 1'b1;
      s_r.x0_d <= 1'b1;
      s_r.x1_d <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign AVS_READDATA = s_r.rdata;
  assign AVS_WAITREQUEST = ~s_r.wait_n;
  assign TIMER0_IRQ = s_r.t0_irq;
  assign TIMER1_IRQ = s_r.t1_irq;
  assign EXTINT0_IRQ = s_r.x0_irq;
  assign EXTINT1_IRQ = s_r.x1_irq;
endmodule : tmr_top

/* rtl/tmr_pkg.sv */
// Package for the dual timer/counter block: register map, field positions, modes.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package tmr_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_T0_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_T0_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_T1_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_T1_HIGH = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_VECTOR_ACK = 4'h6;
  // Control register bit positions
  localparam int CTL_T1_OVF = 7;
  localparam int CTL_T1_RUN = 6;
  localparam int CTL_T0_OVF = 5;
  localparam int CTL_T0_RUN = 4;
  localparam int CTL_X1_FLAG = 3;
  localparam int CTL_X1_TYPE = 2;
  localparam int CTL_X0_FLAG = 1;
  localparam int CTL_X0_TYPE = 0;
  // Mode register nibble layout (timer 1 high nibble, timer 0 low nibble)
  localparam int MODE_GATE = 3;
  localparam int MODE_SEL = 2;
  localparam int T1_NIB = 4;
  // Vector acknowledge bits
  localparam int ACK_X0 = 0;
  localparam int ACK_T0 = 1;
  localparam int ACK_X1 = 2;
  localparam int ACK_T1 = 3;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;
  typedef enum logic [1:0] {
    MODE_PRESCALED,
    MODE_FULL16,
    MODE_RELOAD8,
    MODE_SPLIT
  } tmr_mode_t;
endpackage : tmr_pkg

/* rtl/tmr_unit.sv */
// One 16-bit timer/counter with prescaled, 16-bit and auto-reload modes.
// Assumes count enable and byte writes come from the register block.
`timescale 1ns/1ps
module tmr_unit
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic tick_low,
  input wire logic tick_high,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  output logic [7:0] low_byte,
  output logic [7:0] high_byte,
  output logic ovf_low,
  output logic ovf_high
);
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } unit_state_t;
  unit_state_t s_r;
  unit_state_t s_nxt;
  logic [4:0] pre;

  assign low_byte = s_r.low;
  assign high_byte = s_r.high;
  // Prescaled mode uses the low five bits of the low byte as divide-by-32
  assign pre = s_r.low[4:0];

  always_comb
  begin
    s_nxt = s_r;
    ovf_low = 1'b0;
    ovf_high = 1'b0;
    case (tmr_mode_t'(mode))
      MODE_PRESCALED:
      begin
        if (tick_low)
        begin
          s_nxt.low = {3'h0, pre + 5'h01};
          if (pre == PRESCALE_MAX)
          begin
            s_nxt.high = s_r.high + 8'h01;
            ovf_low = (s_r.high == 8'hff);
          end
        end
      end
      MODE_FULL16:
      begin
        if (tick_low)
        begin
          {s_nxt.high, s_nxt.low} = {s_r.high, s_r.low} + 16'h0001;
          ovf_low = ({s_r.high, s_r.low} == 16'hffff);
        end
      end
      MODE_RELOAD8:
      begin
        if (tick_low)
        begin
          if (s_r.low == 8'hff)
          begin
            s_nxt.low = s_r.high;
            ovf_low = 1'b1;
          end
          else
          begin
            s_nxt.low = s_r.low + 8'h01;
          end
        end
      end
      default:
      begin
        // Split: low byte counts its own ticks, high byte times on its own
        if (tick_low)
        begin
          s_nxt.low = s_r.low + 8'h01;
          ovf_low = (s_r.low == 8'hff);
        end
        if (tick_high)
        begin
          s_nxt.high = s_r.high + 8'h01;
          ovf_high = (s_r.high == 8'hff);
        end
      end
    endcase
    // Software write wins over counting in the same cycle
    if (wr_low)
    begin
      s_nxt.low = wdata;
    end
    if (wr_high)
    begin
      s_nxt.high = wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '{low: COUNT_RST, high: COUNT_RST};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule : tmr_unit

/* dv/tmr_pins_model.sv */
// Far-side pins: event sources and interrupt pins of the timer block.
// Assumes one clock; pins change only after a rising edge.
`timescale 1ns/1ps
module tmr_pins_model
(
  input wire logic clk,
  input wire logic [1:0] ev_en,
  input wire logic [1:0] x_lvl,
  output logic [1:0] ev_out,
  output logic [1:0] x_out
);
  // Event pins toggle while enabled: one rise every two clocks
  logic [1:0] ev_r = 2'b00;
  logic [1:0] x_r = 2'b11;
  always @(posedge clk)
  begin
    ev_r <= ev_en & ~ev_r;
    x_r <= x_lvl;
  end
  assign ev_out = ev_r;
  assign x_out = x_r;
endmodule : tmr_pins_model

/* dv/tmr_top_assertions.sv */
// Port checker for the dual timer block.
// Assumes the master holds each request until waitrequest is low.
`timescale 1ns/1ps
module tmr_top_assertions
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic EXTINT0_IN,
  input wire logic EXTINT1_IN,
  input wire logic TIMER0_IRQ,
  input wire logic TIMER1_IRQ,
  input wire logic EXTINT0_IRQ,
  input wire logic EXTINT1_IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence req_s;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  bus_answer_a: assert property (req_s |=> !AVS_WAITREQUEST) else $error("no answer");
  answer_once_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long");
  read_upper_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper bits");
  t0_clear_a: assert property ($fell(TIMER0_IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("t0 clear");
  t1_clear_a: assert property ($fell(TIMER1_IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("t1 clear");
  x1_clear_a: assert property ($fell(EXTINT1_IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("x1 clear");
  x0_clear_a: assert property ($fell(EXTINT0_IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("x0 clear");
  x0_fall_a: assert property ($fell(EXTINT0_IN) |-> ##[1:2] EXTINT0_IRQ) else $error("x0");
  x1_fall_a: assert property ($fell(EXTINT1_IN) |-> ##[1:2] EXTINT1_IRQ) else $error("x1");
endmodule : tmr_top_assertions
bind tmr_top tmr_top_assertions u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .EXTINT0_IN(EXTINT0_IN), .EXTINT1_IN(EXTINT1_IN),
  .TIMER0_IRQ(TIMER0_IRQ), .TIMER1_IRQ(TIMER1_IRQ), .EXTINT0_IRQ(EXTINT0_IRQ),
  .EXTINT1_IRQ(EXTINT1_IRQ));

/* dv/tmr_top_bench.sv */
// Self-checking bench for the dual timer block.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tmr_top_bench;
  import tmr_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [3:0] addr = 4'h0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h1;
  logic [31:0] rdata;
  logic waitreq;
  logic [1:0] ev, xi, ev_en = 2'b00, x_lvl = 2'b11;
  logic [3:0] irq;
  logic [7:0] q, q2;
  int num_errors = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  tmr_pins_model u_pins (.clk(clk), .ev_en(ev_en), .x_lvl(x_lvl), .ev_out(ev), .x_out(xi));
  tmr_top u_dut (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .EVENT0_IN(ev[0]), .EVENT1_IN(ev[1]), .EXTINT0_IN(xi[0]),
    .EXTINT1_IN(xi[1]), .TIMER0_IRQ(irq[0]), .TIMER1_IRQ(irq[1]), .EXTINT0_IRQ(irq[2]),
    .EXTINT1_IRQ(irq[3]));
  task report_and_stop();
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // One request, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    rd <= 0;
    wr <= 0;
    if (n >= 20)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask : bus
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Bounded wait on one request line, then judged
  task wait_irq(input int i, input int lim);
    int n;
    for (n = 0; n < lim && irq[i] !== 1'b1; n++)
      @(posedge clk);
    `CHK("irq", 1'b1, irq[i])
    // A flag that never came ends the run
    if (irq[i] !== 1'b1)
    begin
      report_and_stop();
    end
  endtask : wait_irq
  task clean(input logic [7:0] mode);
    bus(1, OFS_CONTROL, 8'h00);
    bus(1, OFS_VECTOR_ACK, 8'h0f);
    bus(1, OFS_MODE, mode);
  endtask : clean
  task t_reset_map();
    for (int a = 0; a < 8; a++)
    begin
      bus(0, 4'(a), 8'h00);
      `CHK("reset", 8'h00, q)
    end
    bus(1, 4'h7, 8'h5a);
    be <= 4'h0;
    bus(1, OFS_T0_LOW, 8'h5a);
    be <= 4'h1;
    bus(0, OFS_T0_LOW, 8'h00);
    `CHK("be0", 8'h00, q)
  endtask : t_reset_map
  task t_full16();
    clean(8'h01);
    bus(1, OFS_T0_LOW, 8'hfe);
    bus(1, OFS_T0_HIGH, 8'hff);
    bus(1, OFS_CONTROL, 8'h10);
    wait_irq(0, 20);
    bus(1, OFS_CONTROL, 8'h20);
    bus(0, OFS_T0_HIGH, 8'h00);
    `CHK("hi16", 8'h00, q)
    bus(0, OFS_T0_LOW, 8'h00);
    q2 = q;
    cyc(5);
    bus(0, OFS_T0_LOW, 8'h00);
    `CHK("stopped", q2, q)
    bus(1, OFS_VECTOR_ACK, 8'h02);
    cyc(1);
    `CHK("ack0", 1'b0, irq[0])
  endtask : t_full16
  task t_reload(input int t);
    clean(8'h22);
    bus(1, OFS_T0_LOW + 4'(2 * t), 8'hf0);
    bus(1, OFS_T0_HIGH + 4'(2 * t), 8'h80);
    bus(1, OFS_CONTROL, t ? 8'h40 : 8'h10);
    wait_irq(t, 40);
    bus(0, OFS_T0_LOW + 4'(2 * t), 8'h00);
    `CHK("reload", 1'b1, q[7])
    bus(0, OFS_T0_HIGH + 4'(2 * t), 8'h00);
    `CHK("rl_hi", 8'h80, q)
  endtask : t_reload
  task t_prescale();
    clean(8'h00);
    // Prescaler starts from zero so the overflow time is known
    bus(1, OFS_T0_LOW, 8'h00);
    bus(1, OFS_T0_HIGH, 8'hfe);
    bus(1, OFS_CONTROL, 8'h10);
    cyc(40);
    `CHK("pre_early", 1'b0, irq[0])
    wait_irq(0, 60);
  endtask : t_prescale
  task t_split();
    clean(8'h33);
    bus(1, OFS_T0_LOW, 8'h00);
    bus(1, OFS_T0_HIGH, 8'hfe);
    bus(1, OFS_T1_LOW, 8'h55);
    bus(1, OFS_CONTROL, 8'h40);
    wait_irq(1, 20);
    bus(0, OFS_T1_LOW, 8'h00);
    `CHK("t1_stop", 8'h55, q)
    bus(0, OFS_T0_LOW, 8'h00);
    `CHK("t0_low", 8'h00, q)
  endtask : t_split
  task t_gate();
    clean(8'h0d);
    x_lvl <= 2'b10;
    ev_en <= 2'b11;
    bus(1, OFS_CONTROL, 8'h10);
    cyc(20);
    bus(0, OFS_T0_LOW, 8'h00);
    `CHK("gated", 8'h00, q)
    x_lvl <= 2'b11;
    cyc(20);
    ev_en <= 2'b00;
    bus(0, OFS_T0_LOW, 8'h00);
    `CHK("events", 1'b1, q != 8'h00)
  endtask : t_gate
  task t_extint();
    clean(8'h00);
    bus(1, OFS_CONTROL, 8'h05);
    x_lvl <= 2'b01;
    cyc(3);
    `CHK("x1_fall", 1'b1, irq[3])
    bus(1, OFS_VECTOR_ACK, 8'h04);
    x_lvl <= 2'b11;
    cyc(3);
    `CHK("x1_rise", 1'b1, irq[3])
    `CHK("x0_none", 1'b0, irq[2])
    x_lvl <= 2'b10;
    cyc(3);
    `CHK("x0_fall", 1'b1, irq[2])
    bus(1, OFS_VECTOR_ACK, 8'h01);
    x_lvl <= 2'b11;
    cyc(3);
    `CHK("x0_rise", 1'b0, irq[2])
    bus(1, OFS_CONTROL, 8'h00);
    x_lvl <= 2'b00;
    cyc(3);
    bus(1, OFS_VECTOR_ACK, 8'h05);
    cyc(1);
    `CHK("x_level", 2'b11, irq[3:2])
    x_lvl <= 2'b11;
  endtask : t_extint
  initial
  begin
    cyc(8);
    rst <= 0;
    t_reset_map();
    t_full16();
    t_reload(0);
    t_reload(1);
    t_prescale();
    t_split();
    t_gate();
    t_extint();
    // Reset again in mid-run: registers return to zero
    rst <= 1;
    cyc(2);
    rst <= 0;
    bus(0, OFS_CONTROL, 8'h00);
    `CHK("rerst", 8'h00, q)
    report_and_stop();
  end
endmodule : tmr_top_bench
